// ===== inc/ebt_pkg.sv
package ebt_pkg;
  // ---------------------------------------------------------------
  // register map (byte-wide port)
  // ---------------------------------------------------------------
  localparam logic [2:0] EBT_ADDR_COUNT  = 3'h0;
  localparam logic [2:0] EBT_ADDR_OPTION = 3'h1;
  localparam logic [2:0] EBT_ADDR_CAPSEL = 3'h2;
  localparam logic [2:0] EBT_ADDR_STATUS = 3'h3;
  localparam logic [2:0] EBT_ADDR_MASK   = 3'h4;
  // option field positions
  localparam int EBT_BIT_CS   = 5;
  localparam int EBT_BIT_SE   = 4;
  localparam int EBT_BIT_PSA  = 3;
  localparam int EBT_PS_LSB   = 0;
  localparam int EBT_BIT_XCS  = 0;
  localparam logic [7:0] EBT_OPTION_RST = 8'hff;
  localparam logic [7:0] EBT_COUNT_RST  = 8'h00;
  localparam logic [1:0] EBT_STALL_CYC  = 2'h2;
  localparam logic [7:0] EBT_COUNT_MAX  = 8'hff;

  typedef struct packed {
    logic       cs;
    logic       se;
    logic       prescaler_assign;
    logic [2:0] ps;
    logic       xcs;
  } ebt_ctrl_s;

  typedef struct packed {
    ebt_ctrl_s  ctrl;
    logic [7:0] count;
    logic [7:0] pre;
    logic [1:0] stall;
    logic [2:0] sync;
    logic       src_q;
    logic       flag;
    logic       mask;
    logic [7:0] rdata;
    logic       ovf_pulse;
  } ebt_state_s;
endpackage : ebt_pkg

// ===== logic/ebt_timer.sv
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module ebt_timer
  import ebt_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       external_count_pin_in,
  input  wire logic       cap_sense_osc_in,
  input  wire logic       wdt_clear_in,
  input  wire logic       wdt_tick_in,
  output logic            wdt_tick_out,
  output logic            ovf_gate_out,
  output logic            irq_out
);
  ebt_state_s st_ff;
  ebt_state_s nxt_st;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // terminal prescaler value for a rate code: code n wraps after
  // 2^(n+1) ticks, so code 7 uses the full 8-bit range
  function automatic logic [7:0] rate_lim(input logic [2:0] ps);
    logic [8:0] span;
    span     = 9'h002 << ps;
    rate_lim = 8'(span - 9'h001);
  endfunction : rate_lim

  logic       sel_src;
  logic       edge_seen;
  logic       src_tick;
  logic       tmr_tick;
  logic       inc;
  logic       cnt_wr;
  logic       stat_rd;
  logic       wrap_now;
  logic [7:0] pre_lim;

  // ---------------------------------------------------------------
  // input select, edge detect and strobe decode
  // ---------------------------------------------------------------
  // both count sources are asynchronous; a level only counts once the
  // second and third stages agree, which costs about three cycles of lag
  always_comb begin
    // pick counter input, then the edge polarity
    sel_src   = st_ff.ctrl.xcs ? cap_sense_osc_in : external_count_pin_in;
    edge_seen = (st_ff.sync[2] == st_ff.sync[1]) && (st_ff.sync[1] != st_ff.src_q);
    src_tick  = edge_seen && (st_ff.ctrl.se ? !st_ff.sync[1] : st_ff.sync[1]);
    // timer mode counts every clock, counter mode only synchronized edges
    tmr_tick  = st_ff.ctrl.cs ? src_tick : 1'b1;
    cnt_wr    = wr_in && (addr_in == EBT_ADDR_COUNT);
    stat_rd   = rd_in && (addr_in == EBT_ADDR_STATUS);
    // shared by the prescaler and the watchdog tap
    pre_lim   = rate_lim(st_ff.ctrl.ps);
  end

  // a wrap that survives the write override, watched by the assertions
  assign wrap_now = inc && (st_ff.count == EBT_COUNT_MAX) && !cnt_wr;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // one prescaler: assigned either to the count or to the watchdog
  always_comb begin
    logic pre_out;
    logic [7:0] lim;
    pre_out = 1'b0;
    lim     = 8'h00;
    nxt_st  = st_ff;
    // three-stage synchronizer; only the older two stages are compared
    nxt_st.sync      = {st_ff.sync[1:0], sel_src};
    nxt_st.ovf_pulse = 1'b0;
    if (edge_seen) begin
      nxt_st.src_q = st_ff.sync[1];
    end
    // the same terminal value serves the count side and, halved, the
    // watchdog side; the hardware never runs both at once
    lim = pre_lim;
    if (!st_ff.ctrl.prescaler_assign) begin
      // prescaler in front of the count
      if (tmr_tick) begin
        pre_out    = (st_ff.pre == lim);
        nxt_st.pre = pre_out ? 8'h00 : 8'(st_ff.pre + 8'h01);
      end
      inc = pre_out;
    end else begin
      // count runs 1:1, watchdog gets 1:1..1:128
      inc = tmr_tick;
      if (wdt_clear_in) begin
        nxt_st.pre = 8'h00;
      end else if (wdt_tick_in) begin
        nxt_st.pre = (st_ff.pre >= (lim >> 1)) ? 8'h00 : 8'(st_ff.pre + 8'h01);
      end
    end
    // write inhibit window after a count write
    if (st_ff.stall != 2'h0) begin
      nxt_st.stall = 2'(st_ff.stall - 2'h1);
      inc = 1'b0;
    end
    if (inc) begin
      nxt_st.count = 8'(st_ff.count + 8'h01);
      if (st_ff.count == EBT_COUNT_MAX) begin
        nxt_st.ovf_pulse = 1'b1;
      end
    end
    // register writes take priority over counting
    if (cnt_wr) begin
      nxt_st.count = wdata_in;
      // a write in the wrap cycle wins, so no gate pulse escapes
      nxt_st.ovf_pulse = 1'b0;
      nxt_st.stall = EBT_STALL_CYC;
      if (!st_ff.ctrl.prescaler_assign) begin
        nxt_st.pre = 8'h00;
      end
    end
    // control writes; the prescaler keeps its phase across a reassign,
    // so software should rewrite the count after changing the rate
    if (wr_in && addr_in == EBT_ADDR_OPTION) begin
      nxt_st.ctrl.cs  = wdata_in[EBT_BIT_CS];
      nxt_st.ctrl.se  = wdata_in[EBT_BIT_SE];
      nxt_st.ctrl.prescaler_assign = wdata_in[EBT_BIT_PSA];
      nxt_st.ctrl.ps  = wdata_in[EBT_PS_LSB +: 3];
    end
    if (wr_in && addr_in == EBT_ADDR_CAPSEL) begin
      nxt_st.ctrl.xcs = wdata_in[EBT_BIT_XCS];
    end
    if (wr_in && addr_in == EBT_ADDR_MASK) begin
      nxt_st.mask = wdata_in[0];
    end
    // flag: read clears, a same-cycle wrap wins
    if (stat_rd) begin
      nxt_st.flag = 1'b0;
    end
    if (inc && st_ff.count == EBT_COUNT_MAX && !cnt_wr) begin
      nxt_st.flag = 1'b1;
    end
    // read data stand one cycle after the strobe
    nxt_st.rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        EBT_ADDR_COUNT:  nxt_st.rdata = st_ff.count;
        EBT_ADDR_OPTION: nxt_st.rdata = {2'h3, st_ff.ctrl.cs, st_ff.ctrl.se,
                                         st_ff.ctrl.prescaler_assign, st_ff.ctrl.ps};
        EBT_ADDR_CAPSEL: nxt_st.rdata = {7'h00, st_ff.ctrl.xcs};
        EBT_ADDR_STATUS: nxt_st.rdata = {7'h00, st_ff.flag};
        EBT_ADDR_MASK:   nxt_st.rdata = {7'h00, st_ff.mask};
        default:         nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // count keeps its value on reset in the part; zero here for clean sims
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff       <= '0;
      st_ff.ctrl  <= ebt_ctrl_s'({EBT_OPTION_RST[EBT_BIT_CS], EBT_OPTION_RST[EBT_BIT_SE],
                                  EBT_OPTION_RST[EBT_BIT_PSA], EBT_OPTION_RST[2:0],
                                  1'b0});
      st_ff.count <= EBT_COUNT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_out    = st_ff.rdata;
  assign ovf_gate_out = st_ff.ovf_pulse;
  assign irq_out      = st_ff.flag && st_ff.mask;
  assign wdt_tick_out = st_ff.ctrl.prescaler_assign && wdt_tick_in && !wdt_clear_in
                        && (st_ff.pre >= (pre_lim >> 1));

  // ---------------------------------------------------------------
  // assertions: register port and count
  // ---------------------------------------------------------------
  // two quiet cycles after a count write, unless a second write lands
  a_write_stall: assert property (@(posedge clk_in) disable iff (rst_in)
    (cnt_wr ##1 !cnt_wr) |-> (st_ff.count == $past(wdata_in))
      ##1 (st_ff.count == $past(wdata_in, 2)))
    else $error("count moved inside write stall");

  // every count write reloads the stall counter
  a_stall_load: assert property (@(posedge clk_in) disable iff (rst_in)
    cnt_wr |=> st_ff.stall == EBT_STALL_CYC)
    else $error("stall window not started");

  // a write also drops a wrap that falls in the same cycle
  a_write_cancel: assert property (@(posedge clk_in) disable iff (rst_in)
    cnt_wr |=> !ovf_gate_out)
    else $error("gate pulse after a count write");

  // timer mode at 1:1 steps once a cycle outside the stall
  a_timer_step: assert property (@(posedge clk_in) disable iff (rst_in)
    (!st_ff.ctrl.cs && st_ff.ctrl.prescaler_assign && st_ff.stall == 2'h0 && !cnt_wr)
      |=> st_ff.count == 8'($past(st_ff.count) + 8'h01))
    else $error("timer mode did not step by one");

  // read data stand one cycle after the strobe, zero otherwise
  a_read_data: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_in && addr_in == EBT_ADDR_COUNT && !inc && !cnt_wr)
      |=> rdata_out == $past(st_ff.count))
    else $error("count readback wrong");

  a_read_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    !rd_in |=> rdata_out == 8'h00)
    else $error("read data without a read strobe");

  // unused option bits always read as ones
  a_option_read: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_in && addr_in == EBT_ADDR_OPTION) |=> rdata_out[7:6] == 2'h3)
    else $error("option upper bits wrong");

  // ---------------------------------------------------------------
  // assertions: overflow flag, interrupt and gate
  // ---------------------------------------------------------------
  // wrap sets the flag; a read in the same cycle loses
  a_wrap_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    wrap_now |=> st_ff.flag)
    else $error("overflow flag missed");

  // only a status read may clear the flag
  a_flag_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_ff.flag && !stat_rd) |=> st_ff.flag)
    else $error("flag cleared without a read");

  // a status read with no fresh wrap drops the interrupt
  a_irq_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (stat_rd && !wrap_now) |=> !irq_out)
    else $error("interrupt stayed after status read");

  // the gate source pulses the cycle after each wrap
  a_gate_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    wrap_now |=> ovf_gate_out)
    else $error("gate pulse missed");

  // the gate pulse is one cycle wide
  a_gate_single: assert property (@(posedge clk_in) disable iff (rst_in)
    ovf_gate_out |=> !ovf_gate_out)
    else $error("gate pulse too long");

  // ---------------------------------------------------------------
  // assertions: prescaler and watchdog side
  // ---------------------------------------------------------------
  // a count write restarts the prescaler while the timer owns it
  a_pre_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (cnt_wr && !st_ff.ctrl.prescaler_assign) |=> st_ff.pre == 8'h00)
    else $error("prescaler not cleared by count write");

  // below its terminal value the prescaler steps once per tick
  a_pre_step: assert property (@(posedge clk_in) disable iff (rst_in)
    (!st_ff.ctrl.prescaler_assign && tmr_tick && st_ff.pre != pre_lim && !cnt_wr)
      |=> st_ff.pre == 8'($past(st_ff.pre) + 8'h01))
    else $error("prescaler did not step");

  // at its terminal value the prescaler wraps to zero
  a_pre_wrap: assert property (@(posedge clk_in) disable iff (rst_in)
    (!st_ff.ctrl.prescaler_assign && tmr_tick && st_ff.pre == pre_lim) |=> st_ff.pre == 8'h00)
    else $error("prescaler did not wrap");

  // no watchdog tick while the timer owns the prescaler
  a_wdt_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    !st_ff.ctrl.prescaler_assign |-> !wdt_tick_out)
    else $error("watchdog tick with prescaler on timer");

  // on the watchdog side the prescaler only moves on a tick or clear
  a_wdt_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_ff.ctrl.prescaler_assign && !wdt_tick_in && !wdt_clear_in)
      |=> st_ff.pre == $past(st_ff.pre))
    else $error("prescaler moved without a watchdog tick");

  // ---------------------------------------------------------------
  // assertions: counter input
  // ---------------------------------------------------------------
  // counter mode holds still between accepted edges
  a_counter_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_ff.ctrl.cs && !src_tick && !cnt_wr) |=> st_ff.count == $past(st_ff.count))
    else $error("counter moved without an edge");

  // edge select 0 counts an accepted rising level at 1:1
  a_rise_count: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_ff.ctrl.cs && !st_ff.ctrl.se && st_ff.ctrl.prescaler_assign && edge_seen && st_ff.sync[1]
      && st_ff.stall == 2'h0 && !cnt_wr)
      |=> st_ff.count == 8'($past(st_ff.count) + 8'h01))
    else $error("rising edge not counted");

  // edge select 1 counts an accepted falling level at 1:1
  a_fall_count: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_ff.ctrl.cs && st_ff.ctrl.se && st_ff.ctrl.prescaler_assign && edge_seen && !st_ff.sync[1]
      && st_ff.stall == 2'h0 && !cnt_wr)
      |=> st_ff.count == 8'($past(st_ff.count) + 8'h01))
    else $error("falling edge not counted");

  // ---------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------
  // main scenarios: wrap, counter edge, prescaled step, stall, flag read
  c_wrap: cover property (@(posedge clk_in) st_ff.ovf_pulse);
  c_counter: cover property (@(posedge clk_in) st_ff.ctrl.cs && src_tick);
  c_prescaled: cover property (@(posedge clk_in) !st_ff.ctrl.prescaler_assign && inc);
  c_stall: cover property (@(posedge clk_in) cnt_wr ##1 st_ff.stall == EBT_STALL_CYC);
  c_flag_read: cover property (@(posedge clk_in) stat_rd && st_ff.flag);
endmodule : ebt_timer

// ===== tb/ebt_partner.sv
`timescale 1ns/10ps
module ebt_partner (
  input  wire logic clk_in,
  output logic      external_count_pin_out,
  output logic      cap_sense_osc_out
);
  // sources idle low; a level is held six cycles so the synchronizer sees it
  task automatic drive(input logic sel, input logic lvl);
    @(posedge clk_in);
    if (sel) cap_sense_osc_out <= lvl;
    else external_count_pin_out <= lvl;
    repeat (6) @(posedge clk_in);
  endtask : drive
  initial begin
    external_count_pin_out = 1'b0;
    cap_sense_osc_out      = 1'b0;
  end
endmodule : ebt_partner

// ===== tb/tb_ebt_timer.sv
`timescale 1ns/10ps
module tb_ebt_timer;
  import ebt_pkg::*;
  logic       clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00, rdata_out, a, b;
  logic       pin, osc, wdt_tick_in = 1'b0, wdt_tick_out, ovf_gate_out, irq_out;
  int         n_errors = 0, checks_done = 0, ovf_n = 0;
  always #10 clk_in = ~clk_in;
  ebt_partner partner_u (.clk_in(clk_in), .external_count_pin_out(pin), .cap_sense_osc_out(osc));
  ebt_timer dut_u (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .external_count_pin_in(pin),
    .cap_sense_osc_in(osc), .wdt_clear_in(1'b0), .wdt_tick_in(wdt_tick_in),
    .wdt_tick_out(wdt_tick_out), .ovf_gate_out(ovf_gate_out), .irq_out(irq_out));
  // gate pulses counted here so a missed or doubled pulse shows
  always @(posedge clk_in) if (ovf_gate_out === 1'b1) ovf_n <= ovf_n + 1;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1; addr_in <= ad; wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(negedge clk_in);
  endtask : wr
  task automatic rd(input logic [2:0] ad, output logic [7:0] d);
    @(posedge clk_in);
    rd_in <= 1'b1; addr_in <= ad;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
  endtask : rd
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // watchdog: whole run needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(EBT_ADDR_OPTION, a); chk(a, EBT_OPTION_RST);
    rd(EBT_ADDR_CAPSEL, a); chk(a, 8'h00);
    wr(3'h5, 8'h5a); rd(3'h5, a); chk(a, 8'h00);
    // timer at 1:1, write just below wrap: stall, then step per cycle
    wr(EBT_ADDR_OPTION, 8'hc8);
    wr(EBT_ADDR_COUNT, 8'hfe);
    rd(EBT_ADDR_COUNT, a); chk(a, 8'hfe);
    rd(EBT_ADDR_COUNT, a); chk(a, 8'hff);
    chk({7'h0, irq_out}, 8'h00);
    wr(EBT_ADDR_MASK, 8'h01); chk({7'h0, irq_out}, 8'h01);
    rd(EBT_ADDR_STATUS, a); chk(a, 8'h01);
    chk({7'h0, irq_out}, 8'h00);
    chk(ovf_n[7:0], 8'h01);
    // watchdog tick passes only while the prescaler belongs to it
    for (int p = 0; p < 2; p++) begin
      wr(EBT_ADDR_OPTION, p ? 8'hc0 : 8'hc8);
      @(posedge clk_in) wdt_tick_in <= 1'b1;
      @(negedge clk_in) chk({7'h0, wdt_tick_out}, p ? 8'h00 : 8'h01);
      @(posedge clk_in) wdt_tick_in <= 1'b0;
    end
    // a window of exactly three prescaler periods holds exactly three steps; the last pass, at 1:1, uses six cycles for six steps
    for (int n = 0; n < 9; n++) begin
      wr(EBT_ADDR_OPTION, n < 8 ? (8'hc0 | 8'(n)) : 8'hc8);
      wr(EBT_ADDR_COUNT, 8'h00);
      repeat (4) @(posedge clk_in);
      rd(EBT_ADDR_COUNT, a);
      repeat ((n < 8 ? 3 << (n + 1) : 6) - 2) @(posedge clk_in);
      rd(EBT_ADDR_COUNT, b);
      chk(b - a, n < 8 ? 8'h03 : 8'h06);
    end
    // counter mode: both sources, both edges; the idle source must not count
    for (int x = 0; x < 2; x++) begin
      for (int s = 0; s < 2; s++) begin
        wr(EBT_ADDR_CAPSEL, 8'(x));
        wr(EBT_ADDR_OPTION, s ? 8'hf8 : 8'he8);
        wr(EBT_ADDR_COUNT, 8'h00);
        partner_u.drive(!x, 1'b1);
        partner_u.drive(!x, 1'b0);
        rd(EBT_ADDR_COUNT, a); chk(a, 8'h00);
        partner_u.drive(x, 1'b1);
        rd(EBT_ADDR_COUNT, a); chk(a, s ? 8'h00 : 8'h01);
        partner_u.drive(x, 1'b0);
        rd(EBT_ADDR_COUNT, a); chk(a, 8'h01);
      end
    end
    close_out();
  end
endmodule : tb_ebt_timer
